// [design/bstap_tap.sv]
// Overview of operation
// - Five rising test-clock edges with mode select high reach Test-Logic-Reset from anywhere.
// - State changes on rising test-clock edges, chosen by state and sampled mode select.
// - In Test-Logic-Reset all test logic is off; device runs normally.
// - Run-Test-Idle does nothing unless the instruction asks; here none does.
// - Select-DR branches to data path or Select-IR; Select-IR to instruction path or reset.
// - Capture-IR loads a fixed pattern ending in binary 01.
// - Shift-IR places the instruction shifter between serial in and out.
// - Exit1-IR goes to Pause-IR or Update-IR by mode select.
// - Pause-IR holds the instruction shifter unchanged.
// - Update-IR latches the instruction on the falling test-clock edge.
// - Capture-DR loads the selected data register's capture value.
// - Data path states mirror instruction path states on the selected data register.
// - Instruction register is four bits, least significant nearest serial out.
// - Bypass, boundary and identity registers share one serial in and out.
// - Bypass is one stage, cleared in Capture-DR when selected.
// - Bypass use leaves functional behaviour untouched.
// - Boundary register loads from serial in and reads port cells.
// - The 32-bit read-only identity register is selected by the identity code.
// - Identity word: version 31:28, part 27:12, maker 11:1, bit 0 one.
// - Codes 0, 1 select boundary, 2 identity, F bypass.
// - Code 4 floats all device outputs, bypass forms the serial path.
// - After reset the identity register is selected without loading an instruction.
`timescale 1ns/1ps
`default_nettype none
`include "bstap_params.svh"

module bstap_tap
  import bstap_pkg::*;
#(
  parameter int          BSR_LEN     = 8,
  parameter logic [3:0]  ID_VERSION  = 4'h1,      // Arbitrary value
  parameter logic [15:0] ID_PART     = 16'h00A5,  // Arbitrary value
  parameter logic [10:0] ID_MAKER    = 11'h05A    // Arbitrary value
)
(
  input  wire logic               ref_clk_i,
  input  wire logic               reset_n_i,
  input  wire logic               tck_i,
  input  wire logic               tms_i,
  input  wire logic               tdi_i,
  input  wire logic               trst_n_i,
  input  wire logic [BSR_LEN-1:0] port_in_i,
  input  wire logic [BSR_LEN-1:0] core_out_i,
  output logic                    tdo_o,
  output logic                    tdo_oe_o,
  output logic [BSR_LEN-1:0]      port_out_o,
  output logic                    outputs_en_o,
  output logic                    test_active_o,
  output logic [3:0]              instr_o,
  output bstap_state_t            state_o
);

  // ----------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------
  logic [1:0] tck_s_q, tms_s_q, tdi_s_q, trst_s_q;
  logic [1:0] tck_s_d, tms_s_d, tdi_s_d, trst_s_d;
  logic       tck_prev_q, tck_prev_d;
  logic       tck_rise, tck_fall, trst_act;
  logic [BSR_LEN-1:0] pin_s1_q, pin_s1_d;
  logic [BSR_LEN-1:0] pin_s2_q, pin_s2_d;

  always_comb
  begin
    tck_s_d    = {tck_s_q[0], tck_i};
    tms_s_d    = {tms_s_q[0], tms_i};
    tdi_s_d    = {tdi_s_q[0], tdi_i};
    trst_s_d   = {trst_s_q[0], trst_n_i};
    tck_prev_d = tck_s_q[1];
    pin_s1_d   = port_in_i;
    pin_s2_d   = pin_s1_q;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      tck_s_q    <= 2'h0;
      tms_s_q    <= 2'h3;
      tdi_s_q    <= 2'h0;
      trst_s_q   <= 2'h0;
      tck_prev_q <= 1'b0;
      pin_s1_q   <= '0;
      pin_s2_q   <= '0;
    end
    else
    begin
      tck_s_q    <= tck_s_d;
      tms_s_q    <= tms_s_d;
      tdi_s_q    <= tdi_s_d;
      trst_s_q   <= trst_s_d;
      tck_prev_q <= tck_prev_d;
      pin_s1_q   <= pin_s1_d;
      pin_s2_q   <= pin_s2_d;
    end
  end

  assign tck_rise = tck_s_q[1] & ~tck_prev_q;
  assign tck_fall = ~tck_s_q[1] & tck_prev_q;
  assign trst_act = ~trst_s_q[1];

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  function automatic logic [1:0] dr_sel(input logic [3:0] ins);
    // 0 bypass, 1 boundary, 2 identity
    if (ins == `BSTAP_IR_EXT_TEST || ins == `BSTAP_IR_SAMPLE)
      dr_sel = 2'h1;
    else if (ins == `BSTAP_IR_IDENT)
      dr_sel = 2'h2;
    else
      dr_sel = 2'h0;
  endfunction

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  bstap_state_t state_q, state_d;
  logic         tms;

  assign tms = tms_s_q[1];

  always_comb
  begin
    state_d = state_q;
    if (tck_rise)
    begin
      case (state_q)
        BSTAP_RESET:    state_d = tms ? BSTAP_RESET : BSTAP_IDLE;
        BSTAP_IDLE:     state_d = tms ? BSTAP_SEL_DR : BSTAP_IDLE;
        BSTAP_SEL_DR:   state_d = tms ? BSTAP_SEL_IR : BSTAP_CAP_DR;
        BSTAP_CAP_DR:   state_d = tms ? BSTAP_EXIT1_DR : BSTAP_SHIFT_DR;
        BSTAP_SHIFT_DR: state_d = tms ? BSTAP_EXIT1_DR : BSTAP_SHIFT_DR;
        BSTAP_EXIT1_DR: state_d = tms ? BSTAP_UPD_DR : BSTAP_PAUSE_DR;
        BSTAP_PAUSE_DR: state_d = tms ? BSTAP_EXIT2_DR : BSTAP_PAUSE_DR;
        BSTAP_EXIT2_DR: state_d = tms ? BSTAP_UPD_DR : BSTAP_SHIFT_DR;
        BSTAP_UPD_DR:   state_d = tms ? BSTAP_SEL_DR : BSTAP_IDLE;
        BSTAP_SEL_IR:   state_d = tms ? BSTAP_RESET : BSTAP_CAP_IR;
        BSTAP_CAP_IR:   state_d = tms ? BSTAP_EXIT1_IR : BSTAP_SHIFT_IR;
        BSTAP_SHIFT_IR: state_d = tms ? BSTAP_EXIT1_IR : BSTAP_SHIFT_IR;
        BSTAP_EXIT1_IR: state_d = tms ? BSTAP_UPD_IR : BSTAP_PAUSE_IR;
        BSTAP_PAUSE_IR: state_d = tms ? BSTAP_EXIT2_IR : BSTAP_PAUSE_IR;
        BSTAP_EXIT2_IR: state_d = tms ? BSTAP_UPD_IR : BSTAP_SHIFT_IR;
        BSTAP_UPD_IR:   state_d = tms ? BSTAP_SEL_DR : BSTAP_IDLE;
        default:        state_d = BSTAP_RESET;
      endcase
    end
    if (trst_act)
      state_d = BSTAP_RESET;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      state_q <= BSTAP_RESET;
    else
      state_q <= state_d;
  end

  // ----------------------------------------
  // Instruction shifter and latch
  // ----------------------------------------
  logic [3:0] ir_shift_q, ir_shift_d;
  logic [3:0] ir_latch_q, ir_latch_d;

  always_comb
  begin
    ir_shift_d = ir_shift_q;
    ir_latch_d = ir_latch_q;
    if (tck_rise && state_q == BSTAP_CAP_IR)
      ir_shift_d = `BSTAP_IR_CAPTURE;
    else if (tck_rise && state_q == BSTAP_SHIFT_IR)
      ir_shift_d = {tdi_s_q[1], ir_shift_q[3:1]};
    // Pause and exit states leave the shifter alone
    if (tck_fall && state_q == BSTAP_UPD_IR)
      ir_latch_d = ir_shift_q;
    if (state_q == BSTAP_RESET)
      ir_latch_d = `BSTAP_IR_IDENT;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      ir_shift_q <= `BSTAP_IR_CAPTURE;
      ir_latch_q <= `BSTAP_IR_IDENT;
    end
    else
    begin
      ir_shift_q <= ir_shift_d;
      ir_latch_q <= ir_latch_d;
    end
  end

  // ----------------------------------------
  // Data registers
  // ----------------------------------------
  logic               byp_q, byp_d;
  logic [31:0]        id_q, id_d;
  logic [BSR_LEN-1:0] bsr_q, bsr_d;
  logic [BSR_LEN-1:0] bsr_upd_q, bsr_upd_d;
  logic [1:0]         sel;
  logic [31:0]        id_word;

  assign sel = dr_sel(ir_latch_q);

  always_comb
  begin
    id_word = 32'h0000_0000;
    id_word[`BSTAP_ID_VER_MSB:`BSTAP_ID_VER_LSB]   = ID_VERSION;
    id_word[`BSTAP_ID_PART_MSB:`BSTAP_ID_PART_LSB] = ID_PART;
    id_word[`BSTAP_ID_MFR_MSB:`BSTAP_ID_MFR_LSB]   = ID_MAKER;
    id_word[`BSTAP_ID_MARK_BIT]                    = 1'b1;
  end

  always_comb
  begin
    byp_d     = byp_q;
    id_d      = id_q;
    bsr_d     = bsr_q;
    bsr_upd_d = bsr_upd_q;
    if (tck_rise && state_q == BSTAP_CAP_DR)
    begin
      if (sel == 2'h0)
        byp_d = 1'b0;
      else if (sel == 2'h2)
        id_d = id_word;
      else if (ir_latch_q == `BSTAP_IR_EXT_TEST)
        bsr_d = pin_s2_q;
      else
        bsr_d = core_out_i;
    end
    else if (tck_rise && state_q == BSTAP_SHIFT_DR)
    begin
      if (sel == 2'h0)
        byp_d = tdi_s_q[1];
      else if (sel == 2'h2)
        id_d = {tdi_s_q[1], id_q[31:1]};
      else
        bsr_d = {tdi_s_q[1], bsr_q[BSR_LEN-1:1]};
    end
    if (tck_fall && state_q == BSTAP_UPD_DR && sel == 2'h1)
      bsr_upd_d = bsr_q;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      byp_q     <= 1'b0;
      id_q      <= 32'h0000_0000;
      bsr_q     <= '0;
      bsr_upd_q <= '0;
    end
    else
    begin
      byp_q     <= byp_d;
      id_q      <= id_d;
      bsr_q     <= bsr_d;
      bsr_upd_q <= bsr_upd_d;
    end
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  logic tdo_q, tdo_d, oe_q, oe_d;

  always_comb
  begin
    tdo_d = tdo_q;
    oe_d  = oe_q;
    if (tck_fall)
    begin
      oe_d = (state_q == BSTAP_SHIFT_IR) || (state_q == BSTAP_SHIFT_DR);
      if (state_q == BSTAP_SHIFT_IR)
        tdo_d = ir_shift_q[0];
      else if (sel == 2'h0)
        tdo_d = byp_q;
      else if (sel == 2'h2)
        tdo_d = id_q[0];
      else
        tdo_d = bsr_q[0];
    end
    if (trst_act)
      oe_d = 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      tdo_q <= 1'b0;
      oe_q  <= 1'b0;
    end
    else
    begin
      tdo_q <= tdo_d;
      oe_q  <= oe_d;
    end
  end

  // ----------------------------------------
  // Device-side controls
  // ----------------------------------------
  logic ext_test;

  assign ext_test      = (ir_latch_q == `BSTAP_IR_EXT_TEST) && (state_q != BSTAP_RESET);
  assign test_active_o = ext_test;
  assign port_out_o    = ext_test ? bsr_upd_q : core_out_i;
  assign outputs_en_o  = !((ir_latch_q == `BSTAP_IR_HIGHZ) && (state_q != BSTAP_RESET));
  assign tdo_o         = tdo_q;
  assign tdo_oe_o      = oe_q;
  assign instr_o       = ir_latch_q;
  assign state_o       = state_q;

endmodule

`default_nettype wire

// [design/bstap_params.svh]
`ifndef BSTAP_PARAMS_SVH
`define BSTAP_PARAMS_SVH

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define BSTAP_IR_EXT_TEST    4'h0
`define BSTAP_IR_SAMPLE      4'h1
`define BSTAP_IR_IDENT       4'h2
`define BSTAP_IR_HIGHZ       4'h4
`define BSTAP_IR_BYPASS      4'hF

// ----------------------------------------
// Capture pattern and identity word layout
// ----------------------------------------
`define BSTAP_IR_CAPTURE     4'h1
`define BSTAP_ID_VER_MSB     31
`define BSTAP_ID_VER_LSB     28
`define BSTAP_ID_PART_MSB    27
`define BSTAP_ID_PART_LSB    12
`define BSTAP_ID_MFR_MSB     11
`define BSTAP_ID_MFR_LSB     1
`define BSTAP_ID_MARK_BIT    0

// ----------------------------------------
// Reset sequence length
// ----------------------------------------
`define BSTAP_RESET_TCK_EDGES 5

`endif

// [design/bstap_pkg.sv]
`default_nettype none
package bstap_pkg;

  typedef enum logic [15:0] {
    BSTAP_RESET      = 16'h0001,
    BSTAP_IDLE       = 16'h0002,
    BSTAP_SEL_DR     = 16'h0004,
    BSTAP_CAP_DR     = 16'h0008,
    BSTAP_SHIFT_DR   = 16'h0010,
    BSTAP_EXIT1_DR   = 16'h0020,
    BSTAP_PAUSE_DR   = 16'h0040,
    BSTAP_EXIT2_DR   = 16'h0080,
    BSTAP_UPD_DR     = 16'h0100,
    BSTAP_SEL_IR     = 16'h0200,
    BSTAP_CAP_IR     = 16'h0400,
    BSTAP_SHIFT_IR   = 16'h0800,
    BSTAP_EXIT1_IR   = 16'h1000,
    BSTAP_PAUSE_IR   = 16'h2000,
    BSTAP_EXIT2_IR   = 16'h4000,
    BSTAP_UPD_IR     = 16'h8000
  } bstap_state_t;

endpackage
`default_nettype wire

// [testbench/bstap_tap_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module bstap_tap_monitor
  import bstap_pkg::*;
(
  input wire logic         ref_clk_i,
  input wire logic         reset_n_i,
  input wire logic         trst_n_i,
  input wire logic         tdo_oe_o,
  input wire logic         outputs_en_o,
  input wire logic         test_active_o,
  input wire logic [3:0]   instr_o,
  input wire bstap_state_t state_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // ------
  // Checks
  // ------
  oe_shift_a: assert property (
    $rose(tdo_oe_o) |-> state_o inside {BSTAP_SHIFT_IR, BSTAP_SHIFT_DR})
    else $error("tdo on outside shift");
  reset_instr_a: assert property (
    (state_o == BSTAP_RESET) [*2] |-> instr_o == 4'h2)
    else $error("no ident after reset");
  highz_out_a: assert property (
    instr_o == 4'h4 && state_o != BSTAP_RESET |-> !outputs_en_o)
    else $error("outputs on in highz");
  ext_active_a: assert property (
    test_active_o |-> instr_o == 4'h0 && state_o != BSTAP_RESET)
    else $error("test active wrongly");
  trst_force_a: assert property (
    $fell(trst_n_i) |-> ##[1:4] state_o == BSTAP_RESET)
    else $error("trst ignored");
  sel_dr_a: assert property (
    $changed(state_o) && $past(state_o) == BSTAP_SEL_DR
    |-> state_o inside {BSTAP_CAP_DR, BSTAP_SEL_IR, BSTAP_RESET})
    else $error("bad select branch");
  exit1_ir_a: assert property (
    $changed(state_o) && $past(state_o) == BSTAP_EXIT1_IR
    |-> state_o inside {BSTAP_PAUSE_IR, BSTAP_UPD_IR, BSTAP_RESET})
    else $error("bad exit1 branch");
  exit2_ir_a: assert property (
    $changed(state_o) && $past(state_o) == BSTAP_EXIT2_IR
    |-> state_o inside {BSTAP_SHIFT_IR, BSTAP_UPD_IR, BSTAP_RESET})
    else $error("bad exit2 branch");
endmodule
`default_nettype wire

// [testbench/bstap_tester.sv]
`timescale 1ns/1ps
`default_nettype none
module bstap_tester (
  input  wire logic ref_clk_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_n_o
);
  logic seen;
  initial
  begin
    {tck_o, tms_o, tdi_o, trst_n_o} = 4'b0101;
  end
  // -----------------------------
  // Test clock cycle, low then high
  // -----------------------------
  task automatic step(input logic m, input logic b);
    tms_o = m;
    tdi_o = b;
    repeat (4) @(posedge ref_clk_i);
    #2 tck_o = 1'b1;
    seen = tdo_oe_i ? tdo_i : ~tdo_i; // Released line flips
    repeat (4) @(posedge ref_clk_i);
    #2 tck_o = 1'b0;
  endtask
  task automatic hold_trst(input int n);
    trst_n_o = 1'b0;
    repeat (n) @(posedge ref_clk_i);
    #2 trst_n_o = 1'b1;
  endtask
  // Idle to idle scan, LSB first, optional pause
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, input logic pau = 1'b0);
    step(1'b1, 1'b0);
    if (ir)
      step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1 || (pau && i == 1), din[i]);
      dout[i] = seen;
      if (pau && i == 1)
      begin
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
      end
    end
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
endmodule
`default_nettype wire

// [testbench/bstap_tap_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module bstap_tap_bench import bstap_pkg::*;;
  localparam logic [31:0] ID = {4'h9, 16'h1234, 11'h2A5, 1'b1}; // Arbitrary values
  logic         clk, rst_n, tck, tms, tdi, trst_n, tdo, oe, en, act;
  logic [7:0]   pin, core, pout;
  logic [3:0]   instr;
  logic [31:0]  d;
  bstap_state_t state;
  int           bad_count = 0;
  int           checked = 0;
  bstap_tap #(.ID_VERSION(4'h9), .ID_PART(16'h1234), .ID_MAKER(11'h2A5)) bstap_tap_i (
    .ref_clk_i(clk), .reset_n_i(rst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .port_in_i(pin), .core_out_i(core), .tdo_o(tdo), .tdo_oe_o(oe),
    .port_out_o(pout), .outputs_en_o(en), .test_active_o(act), .instr_o(instr),
    .state_o(state));
  bstap_tester bstap_tester_i (.ref_clk_i(clk), .tdo_i(tdo), .tdo_oe_i(oe), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));
  // -------
  // Helpers
  // -------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ---------
  // Scenarios
  // ---------
  task automatic t_reset();
    chk("state", BSTAP_RESET, state);
    chk("instr", 4'h2, instr);
    chk("oe act en", 3'b001, {oe, act, en});
    bstap_tester_i.hold_trst(4);
    bstap_tester_i.step(1'b0, 1'b0);
  endtask
  task automatic t_ident();
    bstap_tester_i.scan(1'b0, 32, 32'h0, d);
    chk("id", ID, d);
    chk("idle oe", 1'b0, oe);
  endtask
  task automatic t_ir_pause();
    bstap_tester_i.scan(1'b1, 4, 32'hF, d, 1'b1);
    chk("capture", 4'h1, d[3:0]);
    chk("instr", 4'hF, instr);
  endtask
  task automatic t_bypass();
    logic [3:0] c [3] = '{4'hF, 4'h4, 4'h7};
    for (int i = 0; i < 3; i++)
    begin
      bstap_tester_i.scan(1'b1, 4, {28'h0, c[i]}, d);
      bstap_tester_i.scan(1'b0, 4, 32'hB, d);
      chk("bypass", 4'h6, d[3:0]);
      chk("en", c[i] != 4'h4, en);
      chk("pout", core, pout);
    end
  endtask
  task automatic t_boundary();
    bstap_tester_i.scan(1'b1, 4, 32'h1, d);
    bstap_tester_i.scan(1'b0, 8, 32'h96, d);
    chk("sample", core, d[7:0]);
    bstap_tester_i.scan(1'b1, 4, 32'h0, d);
    chk("active", 1'b1, act);
    bstap_tester_i.scan(1'b0, 8, 32'h3C, d);
    chk("extest", pin, d[7:0]);
    chk("drive", 8'h3C, pout);
  endtask
  task automatic t_trst();
    bstap_tester_i.step(1'b1, 1'b0);
    bstap_tester_i.step(1'b0, 1'b0);
    bstap_tester_i.step(1'b0, 1'b0);
    bstap_tester_i.hold_trst(4);
    chk("trst", {BSTAP_RESET, 4'h2}, {state, instr});
    chk("pout", core, pout);
    chk("trst oe", 1'b0, oe);
  endtask
  task automatic t_tms_reset();
    bstap_tester_i.step(1'b0, 1'b0);
    bstap_tester_i.step(1'b1, 1'b0);
    bstap_tester_i.step(1'b0, 1'b0);
    bstap_tester_i.step(1'b0, 1'b0);
    repeat (4) bstap_tester_i.step(1'b1, 1'b0);
    chk("sel_ir", BSTAP_SEL_IR, state);
    bstap_tester_i.step(1'b1, 1'b0);
    chk("tlr", BSTAP_RESET, state);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    {rst_n, pin, core} = {1'b0, 8'h5A, 8'hC3};
    repeat (20) @(posedge clk);
    #2 rst_n = 1'b1;
    t_reset();
    t_ident();
    t_ir_pause();
    t_bypass();
    t_boundary();
    t_trst();
    t_tms_reset();
    stop_test();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    stop_test();
  end
endmodule
bind bstap_tap bstap_tap_monitor bstap_tap_monitor_i (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .trst_n_i(trst_n_i), .tdo_oe_o(tdo_oe_o),
  .outputs_en_o(outputs_en_o), .test_active_o(test_active_o), .instr_o(instr_o),
  .state_o(state_o));
`default_nettype wire
